// ===== src/prl_pkg.sv
package prl_pkg;
   // register file addresses
   localparam logic [6:0] PRL_ADDR_REF_SEL = 7'h31; // reference selection register
   localparam logic [6:0] PRL_ADDR_UNLOCK = 7'h32;  // unlock status register
   localparam logic [3:0] PRL_REF_SEL_RESET = 4'hF; // loop disabled
   localparam logic [3:0] PRL_REF_DISABLED = 4'hF;  // all ones disables loop
   localparam int PRL_UNLOCK_BIT = 0;               // flag position in status word
   // crystal clock and reference frequencies in hertz
   localparam int PRL_XTAL_HZ = 4500000;
   localparam int PRL_HZ_1K = 1000;
   localparam int PRL_HZ_1K25 = 1250;
   localparam int PRL_HZ_2K5 = 2500;
   localparam int PRL_HZ_3K = 3000;
   localparam int PRL_HZ_5K = 5000;
   localparam int PRL_HZ_6K25 = 6250;
   localparam int PRL_HZ_9K = 9000;
   localparam int PRL_HZ_10K = 10000;
   localparam int PRL_HZ_12K5 = 12500;
   localparam int PRL_HZ_25K = 25000;
   localparam int PRL_HZ_50K = 50000;
   localparam int PRL_HZ_100K = 100000;
   localparam int PRL_DIV_W = 13; // largest ratio is 4500
   // error output drive states
   typedef enum logic [1:0] {PRL_EO_FLOAT, PRL_EO_LOW, PRL_EO_HIGH} prl_eo_e;
endpackage : prl_pkg

// ===== src/prl_ref_divider.sv
`timescale 1ns/1ps
// reference divider: one-cycle strobe every ratio crystal cycles
module prl_ref_divider
   import prl_pkg::*;
(
   input wire logic clock,                   // crystal clock
   input wire logic sys_rst,                 // synchronous reset
   input wire logic run,                     // divider enabled
   input wire logic [PRL_DIV_W-1:0] ratio,   // divide ratio
   output logic strobe                       // one pulse per reference period
);
   logic [PRL_DIV_W-1:0] cnt_q; // period counter
   logic [PRL_DIV_W-1:0] cnt_d;
   logic strobe_d;

   // count down from ratio-1; stopped divider restarts its period cleanly
   always_comb begin
      strobe_d = 1'b0;
      if (!run) begin
         cnt_d = ratio - 1'b1;
      end else if (cnt_q == '0) begin
         cnt_d = ratio - 1'b1;
         strobe_d = 1'b1;
      end else begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cnt_q <= '0;
         strobe <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         strobe <= strobe_d;
      end
   end
endmodule : prl_ref_divider

// ===== src/prl_core.sv
`timescale 1ns/1ps
// Functional notes
// - reference derived by dividing crystal clock
// - four-bit code selects reference; some prohibited
// - loop disabled pulls both oscillator inputs
// - loop disabled floats both error outputs
// - select resets ones; kept on chip-enable reset
// - up when divided slower, down when faster
// - disabled loop asserts no requests
// - error low, high, or floating per comparison
// - a request low at the reference strobe sets unlock flag
// - unlock flag updated once per reference period
// - peripheral read clears unlock flag
// - unlock status read-only; writes ignored
// - chip enable low disables whole synthesizer
module prl_core
   import prl_pkg::*;
(
   input wire logic clock,                // 4.5 MHz crystal clock
   input wire logic sys_rst,              // power-on reset, synchronous
   input wire logic clock_stop_rst,       // clock-stop reset
   input wire logic chip_enable,          // low disables synthesizer
   input wire logic divided_strobe,       // one pulse per divided-input period
   input wire logic [6:0] reg_addr,       // register file address
   input wire logic reg_wr,               // register write strobe
   input wire logic [3:0] reg_wdata,      // register write data
   input wire logic reg_rd,               // register read strobe
   input wire logic peripheral_read_instr, // read is the clearing peripheral read
   output logic [3:0] reg_rdata,          // registered read data
   output logic [3:0] ref_freq_select_bits, // current selection
   output logic up_request_n,             // up request, active low
   output logic lower_request_n,          // down request, active low
   output logic error_out_a,              // error pin a level
   output logic error_out_a_oe,           // error pin a drive enable
   output logic error_out_b,              // error pin b level
   output logic error_out_b_oe,           // error pin b drive enable
   output logic high_band_osc_pulldown,   // pull down high-band input
   output logic low_band_osc_pulldown,    // pull down low-band input
   output logic ref_strobe_out            // reference strobe copy
);
   // register file state
   logic [3:0] sel_q; // reference selection
   logic [3:0] sel_d; // next selection
   logic unlock_q; // unlock flip-flop
   logic unlock_d; // next unlock flag
   logic [3:0] rdata_d; // next read data

   // comparator state
   logic ref_seen_q; // reference edge seen, awaiting divided edge
   logic ref_seen_d; // next reference-seen
   logic div_seen_q; // divided edge seen, awaiting reference edge
   logic div_seen_d; // next divided-seen

   // next values of the pin registers
   logic up_d; // next up request, active low
   logic dn_d; // next down request, active low
   logic pd_d; // next pulldown state
   logic active;           // loop running
   logic ref_strobe;       // from reference divider
   logic [PRL_DIV_W-1:0] ratio; // divide ratio for selection
   prl_eo_e eo_d;

   // loop runs only with chip enable high and a non-disabled code
   // chip enable low is not a register reset: it only stops the loop
   assign active = chip_enable && (sel_q != PRL_REF_DISABLED);

   // ratio lookup; prohibited codes fall back to the slowest rate
   // every ratio is the crystal rate over a whole reference rate, so each
   // reference period is an exact count of crystal cycles with no jitter
   always_comb begin
      case (sel_q)
         4'h0: ratio = PRL_DIV_W'(PRL_XTAL_HZ / PRL_HZ_1K25);
         4'h1: ratio = PRL_DIV_W'(PRL_XTAL_HZ / PRL_HZ_2K5);
         4'h2: ratio = PRL_DIV_W'(PRL_XTAL_HZ / PRL_HZ_5K);
         4'h3: ratio = PRL_DIV_W'(PRL_XTAL_HZ / PRL_HZ_10K);
         4'h4: ratio = PRL_DIV_W'(PRL_XTAL_HZ / PRL_HZ_6K25);
         4'h5: ratio = PRL_DIV_W'(PRL_XTAL_HZ / PRL_HZ_12K5);
         4'h6: ratio = PRL_DIV_W'(PRL_XTAL_HZ / PRL_HZ_25K);
         4'h7: ratio = PRL_DIV_W'(PRL_XTAL_HZ / PRL_HZ_50K);
         4'h8: ratio = PRL_DIV_W'(PRL_XTAL_HZ / PRL_HZ_3K);
         4'hC: ratio = PRL_DIV_W'(PRL_XTAL_HZ / PRL_HZ_1K);
         4'hD: ratio = PRL_DIV_W'(PRL_XTAL_HZ / PRL_HZ_9K);
         4'hE: ratio = PRL_DIV_W'(PRL_XTAL_HZ / PRL_HZ_100K);
         // codes 9 to B must not be written; running slow beats stalling the loop
         default: ratio = PRL_DIV_W'(PRL_XTAL_HZ / PRL_HZ_1K);
      endcase
   end

   // reference generator divides the crystal clock
   // a period already loaded keeps its old length; a new code applies at the
   // next reload, so the first period after a change may be longer
   prl_ref_divider u_div (
      .clock(clock),
      .sys_rst(sys_rst),
      .run(active),
      .ratio(ratio),
      .strobe(ref_strobe)
   );

   // register and flag next-state logic
   // read data is registered and holds until the next read strobe
   always_comb begin
      sel_d = sel_q;
      unlock_d = unlock_q;
      rdata_d = reg_rdata;
      if (reg_wr && reg_addr == PRL_ADDR_REF_SEL) begin
         sel_d = reg_wdata;
      end
      // prohibited codes are stored as written; the lookup decides their rate
      // clock-stop reset turns the loop off and beats a write in the same cycle
      if (clock_stop_rst) begin
         sel_d = PRL_REF_SEL_RESET;
      end
      // writes to the status address fall through untouched
      if (reg_rd) begin
         rdata_d = 4'h0;
         if (reg_addr == PRL_ADDR_REF_SEL) begin
            rdata_d = sel_q;
         end else if (reg_addr == PRL_ADDR_UNLOCK) begin
            rdata_d[PRL_UNLOCK_BIT] = unlock_q;
            if (peripheral_read_instr) begin
               unlock_d = 1'b0;
            end
         end
      end
      // set sampled on the reference strobe, and wins over a clearing read
      // the requests looked at are the registered ones, a cycle behind the strobe
      if (ref_strobe && (!up_request_n || !lower_request_n)) begin
         unlock_d = 1'b1;
      end
   end

   // register state; chip-enable reset is not a reset here so selection survives it
   // clock-stop reset reaches the selection through sel_d, so its copy keeps step
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sel_q <= PRL_REF_SEL_RESET;
      end else begin
         sel_q <= sel_d;
      end
      // only power-on reset clears the flag and the read data
      if (sys_rst) begin
         unlock_q <= 1'b0;
         reg_rdata <= 4'h0;
      end else begin
         unlock_q <= unlock_d;
         reg_rdata <= rdata_d;
      end
   end

   // phase-frequency detector: whichever edge arrives first raises its request
   // the request stands until the other strobe arrives, so its width tracks the
   // phase error; strobes that meet in one cycle count as in phase
   always_comb begin
      ref_seen_d = ref_seen_q;
      div_seen_d = div_seen_q;
      if (!active) begin
         ref_seen_d = 1'b0;
         div_seen_d = 1'b0;
      end else if (ref_strobe && divided_strobe) begin
         ref_seen_d = 1'b0; // in phase
         div_seen_d = 1'b0;
      end else if (ref_strobe) begin
         ref_seen_d = !div_seen_q;
         div_seen_d = 1'b0;
      end else if (divided_strobe) begin
         div_seen_d = !ref_seen_q;
         ref_seen_d = 1'b0;
      end
      up_d = !ref_seen_d;   // divided lagging: raise frequency
      dn_d = !div_seen_d;   // divided leading: lower frequency
      // both oscillator inputs are pulled down whenever the loop is off
      pd_d = !active;
      // charge pump: up drives low, down drives high, neither floats
      if (!active) begin
         eo_d = PRL_EO_FLOAT;
      end else if (!up_d) begin
         eo_d = PRL_EO_LOW;
      end else if (!dn_d) begin
         eo_d = PRL_EO_HIGH;
      end else begin
         eo_d = PRL_EO_FLOAT;
      end
   end

   // comparator and pin registers; outputs come from flops
   // both error pins carry one level and one drive enable
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ref_seen_q <= 1'b0;
         div_seen_q <= 1'b0;
         up_request_n <= 1'b1;
         lower_request_n <= 1'b1;
         error_out_a <= 1'b0;
         error_out_a_oe <= 1'b0;
         error_out_b <= 1'b0;
         error_out_b_oe <= 1'b0;
         high_band_osc_pulldown <= 1'b1;
         low_band_osc_pulldown <= 1'b1;
         ref_strobe_out <= 1'b0;
         ref_freq_select_bits <= PRL_REF_SEL_RESET;
      end else begin
         ref_seen_q <= ref_seen_d;
         div_seen_q <= div_seen_d;
         up_request_n <= up_d;
         lower_request_n <= dn_d;
         error_out_a <= (eo_d == PRL_EO_HIGH);
         error_out_a_oe <= (eo_d != PRL_EO_FLOAT);
         error_out_b <= (eo_d == PRL_EO_HIGH);
         error_out_b_oe <= (eo_d != PRL_EO_FLOAT);
         high_band_osc_pulldown <= pd_d;
         low_band_osc_pulldown <= pd_d;
         // strobe copy lags by one cycle, in step with the requests it causes
         ref_strobe_out <= ref_strobe;
         // the copy takes the next value, so it matches the selection register
         ref_freq_select_bits <= sel_d;
      end
   end
endmodule : prl_core

// ===== verif/prl_vco_model.sv
`timescale 1ns/1ps
// loop filter and oscillator stand-in: divided pulses at a period the bench commands
module prl_vco_model (
   input wire logic clock, // crystal clock
   input wire logic [12:0] period, // divided period in cycles
   input wire logic osc_pulled_down, // both oscillator inputs pulled down
   output logic divided_strobe // one pulse per divided period
);
   logic [12:0] cnt_q; // cycle counter
   // a pulled-down input carries no signal, so the pulses stop there
   always_ff @(posedge clock) begin
      if (osc_pulled_down) begin
         cnt_q <= 13'h0001;
         divided_strobe <= 1'b0;
      end else begin
         cnt_q <= (cnt_q >= period) ? 13'h0001 : cnt_q + 13'h0001;
         divided_strobe <= (cnt_q >= period);
      end
   end
endmodule : prl_vco_model

// ===== verif/prl_core_sva.sv
`timescale 1ns/1ps
module prl_core_sva
   import prl_pkg::*;
(
   input wire logic clock, // crystal clock
   input wire logic sys_rst, // power-on reset
   input wire logic chip_enable, // synthesizer enable
   input wire logic reg_rd, // read strobe
   input wire logic [6:0] reg_addr, // address
   input wire logic [3:0] reg_rdata, // read data
   input wire logic [3:0] ref_freq_select_bits, // selection
   input wire logic up_request_n, // up request
   input wire logic lower_request_n, // down request
   input wire logic error_out_a, // pin a level
   input wire logic error_out_a_oe, // pin a enable
   input wire logic error_out_b_oe, // pin b enable
   input wire logic high_band_osc_pulldown, // high-band pulldown
   input wire logic low_band_osc_pulldown, // low-band pulldown
   input wire logic ref_strobe_out // reference strobe
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic off_q; // selection was all ones last cycle
   logic ce_q; // enable last cycle
   // one cycle of history lets registered outputs catch up before they are judged
   always_ff @(posedge clock) begin
      off_q <= (ref_freq_select_bits == PRL_REF_DISABLED);
      ce_q <= chip_enable;
   end
   AST_DIS_PD: assert property (off_q && ref_freq_select_bits == PRL_REF_DISABLED |->
      high_band_osc_pulldown && low_band_osc_pulldown) else $error("pins not pulled down");
   AST_DIS_FLOAT: assert property (off_q && ref_freq_select_bits == PRL_REF_DISABLED |->
      !error_out_a_oe && !error_out_b_oe) else $error("error pins driven while off");
   AST_DIS_NOREQ: assert property (off_q && ref_freq_select_bits == PRL_REF_DISABLED |->
      up_request_n && lower_request_n) else $error("request while off");
   AST_CE_OFF: assert property (!ce_q && !chip_enable |-> up_request_n &&
      lower_request_n && !error_out_a_oe && !error_out_b_oe) else $error("active while disabled");
   // the strobe copy runs one stage behind the divider, so it is judged a cycle later
   AST_CE_NOREF: assert property (!ce_q && !chip_enable |=> !ref_strobe_out)
      else $error("reference strobe while disabled");
   AST_STROBE: assert property (ref_strobe_out |=> !ref_strobe_out)
      else $error("strobe wider than one cycle");
   AST_EO_LOW: assert property (!up_request_n && !$past(up_request_n) |->
      error_out_a_oe && !error_out_a) else $error("error pin not low on up");
   AST_EO_FLOAT: assert property (up_request_n && lower_request_n && $past(up_request_n) &&
      $past(lower_request_n) |-> !error_out_a_oe && !error_out_b_oe) else $error("pins not floating");
   AST_RD_SEL: assert property (reg_rd && reg_addr == PRL_ADDR_REF_SEL |=>
      reg_rdata == $past(ref_freq_select_bits)) else $error("selection read wrong");
endmodule : prl_core_sva
bind prl_core prl_core_sva chk (.clock, .sys_rst, .chip_enable, .reg_rd, .reg_addr, .reg_rdata,
   .ref_freq_select_bits, .up_request_n, .lower_request_n, .error_out_a, .error_out_a_oe,
   .error_out_b_oe, .high_band_osc_pulldown, .low_band_osc_pulldown, .ref_strobe_out);

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import prl_pkg::*;
;
   logic clock = 0, sys_rst = 1, clock_stop_rst = 0, chip_enable = 1; // clock and resets
   logic reg_wr = 0, reg_rd = 0, peripheral_read_instr = 0; // access strobes
   logic [6:0] reg_addr = 7'h00; // address
   logic [3:0] reg_wdata = 4'h0, reg_rdata, ref_freq_select_bits; // data
   logic up_request_n, lower_request_n, error_out_a, error_out_a_oe, error_out_b; // loop outputs
   logic error_out_b_oe, high_band_osc_pulldown, low_band_osc_pulldown, ref_strobe_out;
   logic divided_strobe; // from oscillator model
   logic [12:0] period = 13'd60; // commanded divided period
   int bad_count = 0, n_compared = 0, cyc = 0, lo, hi, skew, i;
   logic [3:0] codes [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
      4'hC, 4'hD, 4'hE}; // every permitted code
   int ratios [12] = '{3600, 1800, 900, 450, 720, 360, 180, 90, 1500, 4500, 500, 45};
   always #4 clock = ~clock;
   prl_core dut (.clock, .sys_rst, .clock_stop_rst, .chip_enable, .divided_strobe, .reg_addr,
      .reg_wr, .reg_wdata, .reg_rd, .peripheral_read_instr, .reg_rdata, .ref_freq_select_bits,
      .up_request_n, .lower_request_n, .error_out_a, .error_out_a_oe, .error_out_b,
      .error_out_b_oe, .high_band_osc_pulldown, .low_band_osc_pulldown, .ref_strobe_out);
   prl_vco_model vco (.clock, .period,
      .osc_pulled_down(high_band_osc_pulldown && low_band_osc_pulldown), .divided_strobe);
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   // hang guard: the whole sequence needs about 36000 cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 80000) begin
         bad_count++;
         finish_test;
      end
   end
   task automatic chk_reg(input logic [3:0] got, input logic [3:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_cnt(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_cnt
   // accesses start and end on a falling edge, so strobes never change twice in a step
   task automatic wr(input logic [6:0] a, input logic [3:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(negedge clock) reg_wr = 0;
      @(negedge clock);
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic p, input logic [3:0] exp);
      reg_addr = a;
      peripheral_read_instr = p;
      reg_rd = 1;
      @(negedge clock) chk_reg(reg_rdata, exp);
      reg_rd = 0;
      peripheral_read_instr = 0;
      @(negedge clock);
   endtask : rd
   // cycles between two reference strobes
   task automatic gap(input int exp);
      int c;
      c = 0;
      while (ref_strobe_out !== 1'b1 && c < 10000) begin
         @(negedge clock);
         c++;
      end
      c = 0;
      do begin
         @(negedge clock);
         c++;
      end while (ref_strobe_out !== 1'b1 && c < 10000);
      chk_cnt(c, exp);
   endtask : gap
   // settle after a period change, then count driven low and high cycles
   task automatic pins(input int per);
      period = per[12:0];
      lo = 0;
      hi = 0;
      skew = 0;
      repeat (200) @(negedge clock);
      repeat (600) begin
         @(negedge clock);
         // both error pins must show the same drive and level
         if ({error_out_b_oe, error_out_b} !== {error_out_a_oe, error_out_a}) skew++;
         if (error_out_a_oe === 1'b1) begin
            if (error_out_a === 1'b0) lo++;
            else hi++;
         end
      end
   endtask : pins
   initial begin
      repeat (8) @(negedge clock);
      sys_rst = 0;
      @(negedge clock) rd(PRL_ADDR_REF_SEL, 0, 4'hF);
      rd(PRL_ADDR_UNLOCK, 1, 4'h0);
      rd(7'h10, 0, 4'h0);
      chk_reg({2'b00, high_band_osc_pulldown, low_band_osc_pulldown}, 4'h3);
      $display("reset test done");
      for (i = 0; i < 12; i++) begin
         wr(PRL_ADDR_REF_SEL, codes[i]);
         rd(PRL_ADDR_REF_SEL, 0, codes[i]);
         chk_reg(ref_freq_select_bits, codes[i]);
         gap(ratios[i]);
      end
      $display("ratio test done");
      pins(60);
      chk_cnt(hi, 0);
      chk_cnt(int'(lo > 0), 1);
      chk_cnt(skew, 0);
      pins(30);
      chk_cnt(lo, 0);
      chk_cnt(int'(hi > 0), 1);
      chk_cnt(skew, 0);
      $display("compare test done");
      rd(PRL_ADDR_UNLOCK, 1, 4'h1);
      repeat (100) @(negedge clock);
      wr(PRL_ADDR_UNLOCK, 4'h0);
      wr(PRL_ADDR_REF_SEL, 4'hF);
      rd(PRL_ADDR_UNLOCK, 0, 4'h1);
      rd(PRL_ADDR_UNLOCK, 1, 4'h1);
      rd(PRL_ADDR_UNLOCK, 1, 4'h0);
      $display("unlock test done");
      wr(PRL_ADDR_REF_SEL, 4'hE);
      chip_enable = 0;
      repeat (200) @(negedge clock);
      chip_enable = 1;
      rd(PRL_ADDR_REF_SEL, 0, 4'hE);
      gap(45);
      $display("enable test done");
      clock_stop_rst = 1;
      @(negedge clock) clock_stop_rst = 0;
      @(negedge clock) rd(PRL_ADDR_REF_SEL, 0, 4'hF);
      chk_reg(ref_freq_select_bits, 4'hF);
      $display("clock stop test done");
      finish_test;
   end
endmodule : tb_top
